// File: core/anpg_top.sv
// partner next page capture, backplane status and shared global control,
// reached over the serial management pins
// assumes synchronous MDC/MDIO inputs and page strobes from the negotiation logic
`timescale 1ns/100ps
`default_nettype none
`include "anpg_consts.svh"
module anpg_top #(
  parameter int CHANNELS = 4,
  parameter logic [2:0] PORT_BASE = 3'h0
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic MDC_IN,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE_OUT,
  input wire logic [CHANNELS*48-1:0] PAGE_WORD_IN,
  input wire logic [CHANNELS-1:0] PAGE_VALID_IN,
  input wire logic [CHANNELS-1:0] RESOLVED_KR_FEC_IN,
  input wire logic [CHANNELS-1:0] RESOLVED_KR_10G_IN,
  input wire logic [CHANNELS-1:0] RESOLVED_KX_1G_IN,
  output logic DATAPATH_RST_OUT,
  output logic [CHANNELS-1:0] CHAN_WR_STROBE_OUT,
  output logic [15:0] CHAN_WR_ADDR_OUT,
  output logic [15:0] CHAN_WR_DATA_OUT
);
  // ==========================================
  // reset release and MDC edge
  logic rst_meta_r;
  logic rst_n;
  logic mdc_d_r;
  logic mdc_rise;
  logic soft_clr;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) mdc_d_r <= 1'b0;
    else mdc_d_r <= MDC_IN;
  end
  assign mdc_rise = MDC_IN && !mdc_d_r;
  // ==========================================
  // frame engine
  anpg_mgmt_if mif ();
  anpg_mdio_frame #(
    .PORT_BASE(PORT_BASE)
  ) anpg_mdio_frame_i (
    .clk_in(MCLK_IN),
    .rst_n_in(rst_n),
    .mdc_rise_in(mdc_rise),
    .mdio_in(MDIO_IN),
    .mdio_out(MDIO_OUT),
    .mdio_oe_out(MDIO_OE_OUT),
    .mif(mif)
  );
  // ==========================================
  // storage
  logic [15:0] gctl_r;
  logic [47:0] page_r [CHANNELS];
  logic [31:0] snap_r [CHANNELS];
  logic [15:0] adr_an_r [CHANNELS];
  logic [15:0] adr_vs_r [CHANNELS];
  logic [CHANNELS-1:0] fec_r;
  logic [CHANNELS-1:0] kr_r;
  logic [CHANNELS-1:0] kx_r;
  logic [1:0] ch;
  logic [4:0] eff_dev;
  logic [15:0] eff_adr;
  logic gw;
  logic rd_lp0;
  logic wr_gctl;
  logic wr_chan;
  assign ch = mif.prtad[1:0];
  assign gw = gctl_r[`ANPG_GCTL_GW_BIT];
  // self-clear lands on the first MDC rise after the write
  assign soft_clr = gctl_r[`ANPG_GCTL_RST_BIT] && mdc_rise;
  // ==========================================
  // address decode
  function automatic logic reg_hit(input logic [4:0] dev, input logic [15:0] adr,
                                   input logic [4:0] want_dev, input logic [15:0] want_adr);
    reg_hit = (dev == want_dev) && (adr == want_adr);
  endfunction : reg_hit
  always_comb begin
    if (mif.c22) begin
      eff_dev = `ANPG_DEV_VS;
      eff_adr = {11'h000, mif.devad};
    end else begin
      eff_dev = mif.devad;
      eff_adr = (mif.devad == `ANPG_DEV_VS) ? adr_vs_r[ch] : adr_an_r[ch];
    end
  end
  assign rd_lp0 = mif.rd_req && reg_hit(eff_dev, eff_adr, `ANPG_DEV_AN, `ANPG_ADR_LP0);
  assign wr_gctl = mif.wr_req && reg_hit(eff_dev, eff_adr, `ANPG_DEV_VS, `ANPG_ADR_GCTL);
  assign wr_chan = mif.wr_req && eff_dev == `ANPG_DEV_VS && !wr_gctl;
  // ==========================================
  // read data; unmapped locations read zero
  always_comb begin
    mif.rdata = 16'h0000;
    if (reg_hit(eff_dev, eff_adr, `ANPG_DEV_VS, `ANPG_ADR_GCTL)) begin
      mif.rdata = gctl_r;
    end else if (reg_hit(eff_dev, eff_adr, `ANPG_DEV_AN, `ANPG_ADR_LP0)) begin
      mif.rdata = page_r[ch][15:0];
    end else if (reg_hit(eff_dev, eff_adr, `ANPG_DEV_AN, `ANPG_ADR_LP1)) begin
      mif.rdata = snap_r[ch][15:0];
    end else if (reg_hit(eff_dev, eff_adr, `ANPG_DEV_AN, `ANPG_ADR_LP2)) begin
      mif.rdata = snap_r[ch][31:16];
    end else if (reg_hit(eff_dev, eff_adr, `ANPG_DEV_AN, `ANPG_ADR_BPST)) begin
      mif.rdata[`ANPG_BPST_FEC_BIT] = fec_r[ch];
      mif.rdata[`ANPG_BPST_KR_BIT] = kr_r[ch];
      mif.rdata[`ANPG_BPST_KX_BIT] = kx_r[ch];
      mif.rdata[`ANPG_BPST_ABIL_BIT] = 1'b1;
    end
  end
  // ==========================================
  // global control, shared by all channels
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      gctl_r <= `ANPG_GCTL_RESET;
    end else if (wr_gctl) begin
      gctl_r <= mif.wdata;
    end else if (soft_clr) begin
      gctl_r <= `ANPG_GCTL_RESET;
    end
  end
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) DATAPATH_RST_OUT <= 1'b1;
    else DATAPATH_RST_OUT <= gctl_r[`ANPG_GCTL_RST_BIT];
  end
  // ==========================================
  // partner page capture and snapshot
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) page_r[i] <= 48'h0000_0000_0000;
    end else if (soft_clr) begin
      for (int i = 0; i < CHANNELS; i++) page_r[i] <= 48'h0000_0000_0000;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (PAGE_VALID_IN[i]) page_r[i] <= PAGE_WORD_IN[i*48 +: 48];
      end
    end
  end
  // upper words freeze at the word0 read so a later page cannot tear them
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) snap_r[i] <= 32'h0000_0000;
    end else if (soft_clr) begin
      for (int i = 0; i < CHANNELS; i++) snap_r[i] <= 32'h0000_0000;
    end else if (rd_lp0) begin
      snap_r[ch] <= page_r[ch][47:16];
    end
  end
  // ==========================================
  // clause 45 address pointers, per channel and device
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        adr_an_r[i] <= 16'h0000;
        adr_vs_r[i] <= 16'h0000;
      end
    end else if (soft_clr) begin
      for (int i = 0; i < CHANNELS; i++) begin
        adr_an_r[i] <= 16'h0000;
        adr_vs_r[i] <= 16'h0000;
      end
    end else if (mif.adr_req) begin
      if (mif.devad == `ANPG_DEV_AN) adr_an_r[ch] <= mif.wdata;
      if (mif.devad == `ANPG_DEV_VS) adr_vs_r[ch] <= mif.wdata;
    end else if (mif.rd_req && !mif.c22 && mif.op == `ANPG_OP_C45_RDINC) begin
      if (mif.devad == `ANPG_DEV_AN) adr_an_r[ch] <= adr_an_r[ch] + 16'h0001;
      if (mif.devad == `ANPG_DEV_VS) adr_vs_r[ch] <= adr_vs_r[ch] + 16'h0001;
    end
  end
  // ==========================================
  // resolved outcome follows the negotiation logic live
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      fec_r <= '0;
      kr_r <= '0;
      kx_r <= '0;
    end else begin
      fec_r <= RESOLVED_KR_FEC_IN;
      kr_r <= RESOLVED_KR_10G_IN;
      kx_r <= RESOLVED_KX_1G_IN;
    end
  end
  // ==========================================
  // channel control write fan-out
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      CHAN_WR_STROBE_OUT <= '0;
      CHAN_WR_ADDR_OUT <= 16'h0000;
      CHAN_WR_DATA_OUT <= 16'h0000;
    end else begin
      CHAN_WR_STROBE_OUT <= '0;
      if (wr_chan) begin
        CHAN_WR_STROBE_OUT <= gw ? '1 : CHANNELS'(1) << ch;
        CHAN_WR_ADDR_OUT <= eff_adr;
        CHAN_WR_DATA_OUT <= mif.wdata;
      end
    end
  end
  // ==========================================
  // checks
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!rst_n);
  logic [31:0] cur_hi;
  logic [31:0] snap_sel;
  assign cur_hi = page_r[ch][47:16];
  assign snap_sel = snap_r[ch];
  property p_abil_one;
    mif.rd_req && reg_hit(eff_dev, eff_adr, `ANPG_DEV_AN, `ANPG_ADR_BPST)
      |-> mif.rdata[0] && mif.rdata[15:5] == 11'h000 && !mif.rdata[2];
  endproperty
  a_abil_one: assert property (p_abil_one) else $error("status bit 0 not one");
  property p_status_follow;
    mif.rd_req && reg_hit(eff_dev, eff_adr, `ANPG_DEV_AN, `ANPG_ADR_BPST) && $stable(ch)
      |-> mif.rdata[4] == $past(RESOLVED_KR_FEC_IN[ch]) && mif.rdata[1] == kx_r[ch];
  endproperty
  a_status_follow: assert property (p_status_follow) else $error("status stale");
  property p_rst_selfclear;
    gctl_r[15] && mdc_rise |=> !gctl_r[15] ##1 !DATAPATH_RST_OUT;
  endproperty
  a_rst_selfclear: assert property (p_rst_selfclear) else $error("reset bit stuck");
  property p_rst_datapath;
    $rose(gctl_r[15]) |=> DATAPATH_RST_OUT;
  endproperty
  a_rst_datapath: assert property (p_rst_datapath) else $error("datapath reset missing");
  property p_rst_regs;
    soft_clr |=> page_r[ch] == 48'h0000_0000_0000 && gctl_r == `ANPG_GCTL_RESET;
  endproperty
  a_rst_regs: assert property (p_rst_regs) else $error("registers not reset");
  property p_bcast;
    wr_chan && gw |=> CHAN_WR_STROBE_OUT == '1 ##1 CHAN_WR_STROBE_OUT == '0;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast write missed");
  property p_single;
    wr_chan && !gw |=> $onehot(CHAN_WR_STROBE_OUT) && CHAN_WR_STROBE_OUT[$past(ch)];
  endproperty
  a_single: assert property (p_single) else $error("single channel write wrong");
  property p_snapshot;
    rd_lp0 |=> snap_sel == $past(cur_hi);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");
  // word0 must reach the shifter that serialises it, not just the read mux
  property p_word0;
    rd_lp0 |=> anpg_mdio_frame_i.sh_r == $past(page_r[ch][15:0]);
  endproperty
  a_word0: assert property (p_word0) else $error("word0 mismatch");
  property p_c22_gctl;
    mif.rd_req && mif.c22 && mif.devad == 5'h00 |-> mif.rdata == gctl_r;
  endproperty
  a_c22_gctl: assert property (p_c22_gctl) else $error("clause 22 decode wrong");
  property p_shared;
    wr_gctl && !mif.wdata[15] |=> gctl_r == $past(mif.wdata);
  endproperty
  a_shared: assert property (p_shared) else $error("global write lost");
  property p_other_dev;
    mif.rd_req && !mif.c22 && mif.devad != `ANPG_DEV_AN && mif.devad != `ANPG_DEV_VS
      |-> mif.rdata == 16'h0000;
  endproperty
  a_other_dev: assert property (p_other_dev) else $error("unmapped device answered");
  property p_c45_vs_gctl;
    mif.rd_req && !mif.c22 && mif.devad == `ANPG_DEV_VS && adr_vs_r[ch] == `ANPG_ADR_GCTL
      |-> mif.rdata == gctl_r;
  endproperty
  a_c45_vs_gctl: assert property (p_c45_vs_gctl) else $error("vendor select wrong");
  property p_page_ro;
    mif.wr_req && !mif.c22 && mif.devad == `ANPG_DEV_AN && !PAGE_VALID_IN[ch] && !soft_clr
      |=> page_r[ch] == $past(page_r[ch]);
  endproperty
  a_page_ro: assert property (p_page_ro) else $error("read only page written");
  property p_ro_no_strobe;
    mif.wr_req && !mif.c22 && mif.devad == `ANPG_DEV_AN |=> CHAN_WR_STROBE_OUT == '0;
  endproperty
  a_ro_no_strobe: assert property (p_ro_no_strobe) else $error("strobe on page write");
  property p_c22_strobe;
    mif.wr_req && mif.c22 && mif.devad != 5'h00 |=> CHAN_WR_STROBE_OUT != '0;
  endproperty
  a_c22_strobe: assert property (p_c22_strobe) else $error("clause 22 write lost");
  property p_strobe_fields;
    wr_chan |=> CHAN_WR_ADDR_OUT == $past(eff_adr) && CHAN_WR_DATA_OUT == $past(mif.wdata);
  endproperty
  a_strobe_fields: assert property (p_strobe_fields) else $error("channel write fields");
  property p_gctl_hold;
    !wr_gctl && !soft_clr |=> $stable(gctl_r);
  endproperty
  a_gctl_hold: assert property (p_gctl_hold) else $error("global control moved");
  property p_dp_low;
    !gctl_r[`ANPG_GCTL_RST_BIT] |=> !DATAPATH_RST_OUT;
  endproperty
  a_dp_low: assert property (p_dp_low) else $error("datapath reset stuck");
  property p_status_kr;
    mif.rd_req && reg_hit(eff_dev, eff_adr, `ANPG_DEV_AN, `ANPG_ADR_BPST) && $stable(ch)
      |-> mif.rdata[3] == $past(RESOLVED_KR_10G_IN[ch])
        && mif.rdata[1] == $past(RESOLVED_KX_1G_IN[ch]);
  endproperty
  a_status_kr: assert property (p_status_kr) else $error("status kr kx stale");
  // ==========================================
  // per channel storage checks; every channel, not only the addressed one
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan_chk
    property p_capture;
      @(posedge MCLK_IN) disable iff (!rst_n)
      PAGE_VALID_IN[g] && !soft_clr |=> page_r[g] == $past(PAGE_WORD_IN[g*48 +: 48]);
    endproperty
    a_capture: assert property (p_capture) else $error("page not captured");
    property p_snap_hold;
      @(posedge MCLK_IN) disable iff (!rst_n)
      !(rd_lp0 && ch == 2'(g)) && !soft_clr |=> $stable(snap_r[g]);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved");
  end
endmodule : anpg_top
`default_nettype wire

// File: core/anpg_consts.svh
// offsets, field positions, reset values and timing counts of the partner page block
// assumes inclusion by bare name from the core files
`ifndef ANPG_CONSTS_SVH
`define ANPG_CONSTS_SVH
// ==========================================
// device selects and register offsets
`define ANPG_DEV_AN 5'h07
`define ANPG_DEV_VS 5'h1E
`define ANPG_ADR_GCTL 16'h0000
`define ANPG_ADR_LP0 16'h0019
`define ANPG_ADR_LP1 16'h001A
`define ANPG_ADR_LP2 16'h001B
`define ANPG_ADR_BPST 16'h0030
// ==========================================
// field positions and reset values
`define ANPG_GCTL_RESET 16'h0020
`define ANPG_GCTL_RST_BIT 15
`define ANPG_GCTL_GW_BIT 11
`define ANPG_BPST_FEC_BIT 4
`define ANPG_BPST_KR_BIT 3
`define ANPG_BPST_KX_BIT 1
`define ANPG_BPST_ABIL_BIT 0
// ==========================================
// frame timing and opcodes
`define ANPG_PREAMBLE_BITS 6'h20
`define ANPG_HDR_LAST 6'h0C
`define ANPG_DATA_LAST 6'h0F
`define ANPG_OP_C22_RD 2'h2
`define ANPG_OP_WR 2'h1
`define ANPG_OP_C45_ADR 2'h0
`define ANPG_OP_C45_RDINC 2'h2
`endif

// File: core/anpg_pkg.sv
// types shared by the partner page block
// assumes nothing beyond a SystemVerilog compiler
package anpg_pkg;
  // ==========================================
  // serial frame engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HDR = 4'b0010,
    ST_TA = 4'b0100,
    ST_DATA = 4'b1000
  } anpg_state_e;
  typedef logic [15:0] anpg_word_t;
endpackage : anpg_pkg

// File: core/anpg_mgmt_if.sv
// request and answer signals between the frame engine and the register bank
// assumes one clock; pulses last one cycle
`timescale 1ns/100ps
`default_nettype none
interface anpg_mgmt_if;
  logic rd_req;
  logic wr_req;
  logic adr_req;
  logic c22;
  logic [1:0] op;
  logic [4:0] prtad;
  logic [4:0] devad;
  anpg_pkg::anpg_word_t wdata;
  anpg_pkg::anpg_word_t rdata;
  modport frame (output rd_req, wr_req, adr_req, c22, op, prtad, devad, wdata, input rdata);
  modport regs (input rd_req, wr_req, adr_req, c22, op, prtad, devad, wdata, output rdata);
endinterface : anpg_mgmt_if
`default_nettype wire

// File: core/anpg_mdio_frame.sv
// serial management frame engine: preamble, header, turnaround, data
// assumes MDC sampled as a plain input, at least four clocks per MDC period
`timescale 1ns/100ps
`default_nettype none
`include "anpg_consts.svh"
module anpg_mdio_frame #(
  parameter logic [2:0] PORT_BASE = 3'h0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic mdc_rise_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  anpg_mgmt_if.frame mif
);
  anpg_pkg::anpg_state_e state_r;
  logic [5:0] cnt_r;
  logic [11:0] hdr_r;
  logic [15:0] sh_r;
  logic rd_r;
  logic mine_r;
  logic [12:0] hdr_full;
  logic hdr_done;
  logic hdr_read;
  logic data_done;
  assign hdr_full = {hdr_r, mdio_in};
  assign hdr_done = mdc_rise_in && state_r == anpg_pkg::ST_HDR && cnt_r == `ANPG_HDR_LAST;
  assign data_done = mdc_rise_in && state_r == anpg_pkg::ST_DATA && cnt_r == `ANPG_DATA_LAST;
  assign hdr_read = hdr_full[12] ? (hdr_full[11:10] == `ANPG_OP_C22_RD) : hdr_full[11];
  // ==========================================
  // frame sequencing; one preamble per frame, no suppression
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= anpg_pkg::ST_IDLE;
      cnt_r <= 6'h00;
      hdr_r <= 12'h000;
      sh_r <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else if (mif.rd_req) begin
      sh_r <= mif.rdata;
    end else if (mdc_rise_in) begin
      unique case (state_r)
        anpg_pkg::ST_IDLE: begin
          if (mdio_in) begin
            cnt_r <= (cnt_r == `ANPG_PREAMBLE_BITS) ? cnt_r : cnt_r + 6'h01;
          end else begin
            if (cnt_r == `ANPG_PREAMBLE_BITS) state_r <= anpg_pkg::ST_HDR;
            cnt_r <= 6'h00;
          end
        end
        anpg_pkg::ST_HDR: begin
          hdr_r <= hdr_full[11:0];
          cnt_r <= cnt_r + 6'h01;
          if (hdr_done) begin
            state_r <= anpg_pkg::ST_TA;
            cnt_r <= 6'h00;
          end
        end
        anpg_pkg::ST_TA: begin
          if (cnt_r == 6'h00) begin
            mdio_oe_out <= rd_r && mine_r;
            mdio_out <= 1'b0;
            cnt_r <= 6'h01;
          end else begin
            state_r <= anpg_pkg::ST_DATA;
            cnt_r <= 6'h00;
            mdio_out <= sh_r[15];
            sh_r <= {sh_r[14:0], mdio_in};
          end
        end
        anpg_pkg::ST_DATA: begin
          mdio_out <= sh_r[15];
          sh_r <= {sh_r[14:0], mdio_in};
          cnt_r <= cnt_r + 6'h01;
          if (data_done) begin
            mdio_oe_out <= 1'b0;
            state_r <= anpg_pkg::ST_IDLE;
            cnt_r <= 6'h00;
          end
        end
      endcase
    end
  end
  // ==========================================
  // header fields and request pulses
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {rd_r, mine_r, mif.c22, mif.op, mif.prtad, mif.devad} <= 15'h0000;
      {mif.rd_req, mif.wr_req, mif.adr_req} <= 3'h0;
      mif.wdata <= 16'h0000;
    end else begin
      mif.rd_req <= hdr_done && hdr_read && hdr_full[9:7] == PORT_BASE;
      mif.wr_req <= data_done && !rd_r && mine_r && mif.op == `ANPG_OP_WR;
      mif.adr_req <= data_done && !rd_r && mine_r && !mif.c22 && mif.op == `ANPG_OP_C45_ADR;
      if (data_done) mif.wdata <= {sh_r[14:0], mdio_in};
      if (hdr_done) begin
        rd_r <= hdr_read;
        mine_r <= hdr_full[9:7] == PORT_BASE;
        mif.c22 <= hdr_full[12];
        mif.op <= hdr_full[11:10];
        mif.prtad <= hdr_full[9:5];
        mif.devad <= hdr_full[4:0];
      end
    end
  end
endmodule : anpg_mdio_frame
`default_nettype wire

// File: tb/anpg_station.sv
// management station model: frames on MDC and MDIO, samples read data
// assumes a pulled-up MDIO wire resolved by the bench, device on clk_in
`timescale 1ns/100ps
`default_nettype none
module anpg_station (
  input wire logic clk_in,
  input wire logic mdio_in,
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_out,
  output logic rd_valid_out,
  output logic [15:0] rd_data_out
);
  // ==========================================
  // bit timing
  // mdc parked low between frames; 8 clocks a bit, twice the minimum
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_data_out = 16'h0000;
  end
  task automatic bit_cyc(input logic b, input logic drv, output logic smp);
    mdc_out <= 1'b0;
    mdio_out <= b;
    mdio_oe_out <= drv;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in) smp = mdio_in;
    @(posedge clk_in) mdc_out <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask : bit_cyc
  // ==========================================
  // frames
  task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] prt,
      input logic [4:0] dev, input logic [15:0] data, input logic rd);
    logic [31:0] hdr;
    logic s;
    logic [15:0] v;
    hdr = {st, op, prt, dev, 2'b10, data};
    v = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      bit_cyc(1'b1, 1'b1, s);
    end
    // released from the turnaround on, so the device owns the wire
    for (int i = 31; i >= 0; i--) begin
      bit_cyc(hdr[i], !(rd && i < 18), s);
      if (i < 16) v[i] = s;
    end
    @(posedge clk_in);
    mdc_out <= 1'b0;
    mdio_oe_out <= 1'b0;
    if (rd) begin
      rd_data_out <= v;
      rd_valid_out <= 1'b1;
      @(posedge clk_in);
      rd_valid_out <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
  endtask : frame
  task automatic c45(input logic [4:0] prt, input logic [4:0] dev, input logic [15:0] adr,
      input logic [15:0] data, input logic rd);
    frame(2'b00, 2'b00, prt, dev, adr, 1'b0);
    frame(2'b00, rd ? 2'b11 : 2'b01, prt, dev, data, rd);
  endtask : c45
  task automatic c22(input logic [4:0] prt, input logic [4:0] reg_num, input logic [15:0] data,
      input logic rd);
    frame(2'b01, rd ? 2'b10 : 2'b01, prt, reg_num, data, rd);
  endtask : c22
endmodule : anpg_station
`default_nettype wire

// File: tb/anpg_top_tb.sv
// self-checking bench for the partner page and global control block
// assumes the station model drives the management pins
`timescale 1ns/100ps
`default_nettype none
module anpg_top_tb;
  logic mclk;
  logic rst_n;
  logic [191:0] page_word;
  logic [3:0] page_valid;
  logic [3:0] r_fec;
  logic [3:0] r_kr;
  logic [3:0] r_kx;
  logic mdc, st_mdio, st_oe, dut_mdio, dut_oe, mdio_w, rd_valid, dp_rst;
  logic [15:0] rd_data, wr_addr, wr_data, d;
  logic [3:0] strobe;
  logic [47:0] pg, pg2;
  logic [1:0] ch;
  logic [4:0] prt;
  logic dp_seen;
  logic [15:0] exp_q[$];
  logic [35:0] wr_q[$];
  int n_errors, checks, seed;
  // ==========================================
  // wiring; pull-up when nobody drives
  assign mdio_w = dut_oe ? dut_mdio : (st_oe ? st_mdio : 1'b1);
  anpg_top anpg_top_i (.MCLK_IN(mclk), .RST_N_IN(rst_n), .MDC_IN(mdc), .MDIO_IN(mdio_w),
    .MDIO_OUT(dut_mdio), .MDIO_OE_OUT(dut_oe), .PAGE_WORD_IN(page_word),
    .PAGE_VALID_IN(page_valid), .RESOLVED_KR_FEC_IN(r_fec), .RESOLVED_KR_10G_IN(r_kr),
    .RESOLVED_KX_1G_IN(r_kx), .DATAPATH_RST_OUT(dp_rst), .CHAN_WR_STROBE_OUT(strobe),
    .CHAN_WR_ADDR_OUT(wr_addr), .CHAN_WR_DATA_OUT(wr_data));
  anpg_station anpg_station_i (.clk_in(mclk), .mdio_in(mdio_w), .mdc_out(mdc),
    .mdio_out(st_mdio), .mdio_oe_out(st_oe), .rd_valid_out(rd_valid), .rd_data_out(rd_data));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========================================
  // checking
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(36'h1, 36'h0);
      else chk({20'h0_0000, rd_data}, {20'h0_0000, exp_q.pop_front()});
    end
    if (strobe !== 4'h0) begin
      if (wr_q.size() == 0) chk({strobe, wr_addr, wr_data}, 36'h0);
      else chk({strobe, wr_addr, wr_data}, wr_q.pop_front());
    end
    if (dp_rst === 1'b1) dp_seen <= 1'b1;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    close_out();
  end
  // ==========================================
  // drivers
  task automatic rd45(input logic [4:0] p, input logic [4:0] dv, input logic [15:0] a,
      input logic [15:0] e);
    exp_q.push_back(e);
    anpg_station_i.c45(p, dv, a, 16'h0000, 1'b1);
  endtask : rd45
  task automatic wr45(input logic [4:0] p, input logic [4:0] dv, input logic [15:0] a,
      input logic [15:0] v);
    anpg_station_i.c45(p, dv, a, v, 1'b0);
  endtask : wr45
  task automatic pulse_page(input logic [47:0] v);
    page_word[ch*48 +: 48] <= v;
    page_valid[ch] <= 1'b1;
    @(posedge mclk);
    page_valid <= 4'h0;
    @(posedge mclk);
  endtask : pulse_page
  // ==========================================
  // scenarios
  initial begin
    seed = 22759;
    n_errors = 0;
    checks = 0;
    dp_seen = 1'b0;
    rst_n = 1'b0;
    page_word = '0;
    page_valid = 4'h0;
    r_fec = 4'h0;
    r_kr = 4'h0;
    r_kx = 4'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rd45(5'h00, 5'h07, 16'h0019, 16'h0000);
    rd45(5'h00, 5'h07, 16'h001A, 16'h0000);
    rd45(5'h00, 5'h07, 16'h001B, 16'h0000);
    rd45(5'h00, 5'h07, 16'h0030, 16'h0001);
    rd45(5'h00, 5'h1E, 16'h0000, 16'h0020);
    rd45(5'h00, 5'h07, 16'h0040, 16'h0000);
    rd45(5'h04, 5'h07, 16'h0030, 16'hFFFF);
    $display("test defaults done");
    ch = 2'($random(seed));
    prt = {3'h0, ch};
    pg = {16'($random(seed)), 32'($random(seed))};
    pg2 = {16'($random(seed)), 32'($random(seed))};
    pulse_page(pg);
    wr45(prt, 5'h07, 16'h0019, ~pg[15:0]);
    rd45(prt, 5'h07, 16'h0019, pg[15:0]);
    pulse_page(pg2);
    rd45(prt, 5'h07, 16'h001A, pg[31:16]);
    rd45(prt, 5'h07, 16'h001B, pg[47:32]);
    rd45(prt, 5'h07, 16'h0019, pg2[15:0]);
    rd45(prt, 5'h07, 16'h001B, pg2[47:32]);
    // read with increment, then a bare read at the bumped pointer
    exp_q.push_back(pg2[31:16]);
    anpg_station_i.frame(2'b00, 2'b00, prt, 5'h07, 16'h001A, 1'b0);
    anpg_station_i.frame(2'b00, 2'b10, prt, 5'h07, 16'h0000, 1'b1);
    exp_q.push_back(pg2[47:32]);
    anpg_station_i.frame(2'b00, 2'b11, prt, 5'h07, 16'h0000, 1'b1);
    $display("test page capture done");
    for (int k = 0; k < 8; k++) begin
      r_fec[ch] <= k[2];
      r_kr[ch] <= k[1];
      r_kx[ch] <= k[0];
      @(posedge mclk);
      rd45(prt, 5'h07, 16'h0030, {11'h000, k[2], k[1], 1'b0, k[0], 1'b1});
    end
    $display("test status done");
    d = 16'($random(seed));
    wr_q.push_back({4'h4, 16'h0005, d});
    wr45(5'h02, 5'h1E, 16'h0005, d);
    wr45(5'h00, 5'h1E, 16'h0000, 16'h0820);
    rd45(5'h01, 5'h1E, 16'h0000, 16'h0820);
    wr_q.push_back({4'hF, 16'h0006, ~d});
    wr45(5'h01, 5'h1E, 16'h0006, ~d);
    wr_q.push_back({4'hF, 16'h0007, d});
    anpg_station_i.c22(5'h03, 5'h07, d, 1'b0);
    exp_q.push_back(16'h0820);
    anpg_station_i.c22(5'h02, 5'h00, 16'h0000, 1'b1);
    $display("test global write done");
    pulse_page(pg);
    dp_seen <= 1'b0;
    wr45(5'h00, 5'h1E, 16'h0000, 16'h8820);
    chk({35'h0, dp_seen}, 36'h1);
    rd45(5'h00, 5'h1E, 16'h0000, 16'h0020);
    rd45(prt, 5'h07, 16'h0019, 16'h0000);
    chk({35'h0, dp_rst}, 36'h0);
    // hardware reset must match the soft one
    wr45(5'h00, 5'h1E, 16'h0000, 16'h0820);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rd45(5'h00, 5'h1E, 16'h0000, 16'h0020);
    chk({35'h0, dp_rst}, 36'h0);
    $display("test resets done");
    chk(36'(exp_q.size() + wr_q.size()), 36'h0);
    close_out();
  end
endmodule : anpg_top_tb
`default_nettype wire
